// file: design/aams_pkg.sv
/*
  Package of the asynchronous memory strobe sequencer: field widths,
  timing constants, access request and timing setting carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package aams_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned CNT_W  = 6;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;

  // ----------------------------------------
  // Timing and reset values
  // ----------------------------------------
  localparam logic [CNT_W-1:0]  READY_LEAD = 6'h02;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 6'h01;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST   = 32'h00000000;
  localparam logic [BE_W-1:0]   BE_N_RST   = 4'hF;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0]   byte_en;
    logic [DATA_W-1:0] wdata;
  } aams_req_t;

  typedef struct packed {
    logic [CNT_W-1:0] read_setup_cycles;
    logic [CNT_W-1:0] read_strobe_cycles;
    logic [CNT_W-1:0] read_hold_cycles;
    logic [CNT_W-1:0] write_setup_cycles;
    logic [CNT_W-1:0] write_strobe_cycles;
    logic [CNT_W-1:0] write_hold_cycles;
  } aams_timing_t;

endpackage

// file: design/aams_sync2.sv
/*
  Two flip-flop level synchroniser.
  Assumes an asynchronous input and one destination clock.
*/
`timescale 1ns/10ps
`default_nettype none

module aams_sync2 (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta     <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// file: design/aams_phase_cnt.sv
/*
  Phase down-counter: loads a value, counts down to zero and holds.
  Assumes the caller loads it at each phase entry.
*/
`timescale 1ns/10ps
`default_nettype none

module aams_phase_cnt
  import aams_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output var  logic [CNT_W-1:0] count
);

  logic [CNT_W-1:0] next_count;

  always_comb begin
    if (load) begin
      next_count = load_val;
    end else if (count != CNT_ZERO) begin
      next_count = count - CNT_ONE;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= CNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

endmodule

`default_nettype wire

// file: design/aams_sequencer.sv
/*
  Asynchronous memory strobe sequencer: runs setup, strobe and hold
  phases for reads and writes to SRAM or EPROM class memories.
  Assumes clk is the first memory output clock, the timing settings
  are stable while an access runs, and the user side holds a request
  until it is taken.
*/
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Ready input passes a two-flop synchroniser
// - Ready sampled only in last two strobe cycles
// - Low ready stretches strobe one cycle each
// - Strobe ends two cycles after ready high
// - Selects valid read-setup cycles before read strobe
// - Selects and data valid write-setup before strobe
// - Selects and data held write-hold after strobe
// - All phases counted in memory clock periods
// - Six timing settings: read/write setup, strobe, hold
// - Selects: chip select, byte enables, address, OE
// - Control pins act as OE, read, write strobes
// - Strobes change only on rising clock edges
module aams_sequencer
  import aams_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              req_valid,
  input  wire aams_req_t         req,
  input  wire aams_timing_t      timing,
  output var  logic              req_ready,
  output var  logic              rd_valid,
  output var  logic [DATA_W-1:0] rd_data,
  input  wire logic              async_ready_in,
  output var  logic              chip_select_n,
  output var  logic [BE_W-1:0]   byte_enable_n,
  output var  logic [ADDR_W-1:0] ext_addr,
  input  wire logic [DATA_W-1:0] ext_data_in,
  output var  logic [DATA_W-1:0] ext_data_out,
  output var  logic              ext_data_oe_n,
  output var  logic              output_enable_n,
  output var  logic              read_strobe_n,
  output var  logic              write_strobe_n
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_WAIT   = 5'b01000,
    ST_HOLD   = 5'b10000
  } aams_state_t;

  aams_state_t       state;
  aams_state_t       next_state;
  logic              is_write;
  logic              next_is_write;
  logic              ready_sync;
  logic              cnt_load;
  logic [CNT_W-1:0]  cnt_val;
  logic [CNT_W-1:0]  cnt;
  logic              next_req_ready;
  logic              next_rd_valid;
  logic [DATA_W-1:0] next_rd_data;
  logic              next_chip_select_n;
  logic [BE_W-1:0]   next_byte_enable_n;
  logic [ADDR_W-1:0] next_ext_addr;
  logic [DATA_W-1:0] next_ext_data_out;
  logic              next_ext_data_oe_n;
  logic              next_output_enable_n;
  logic              next_read_strobe_n;
  logic              next_write_strobe_n;
  logic              in_strobe;

  // ----------------------------------------
  // Ready synchroniser and phase counter
  // ----------------------------------------
  aams_sync2 u_ready_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (async_ready_in),
    .sync_out (ready_sync)
  );

  aams_phase_cnt u_phase_cnt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (cnt_load),
    .load_val (cnt_val),
    .count    (cnt)
  );

  // Cycles minus one; a zero setting counts as one period
  function automatic logic [CNT_W-1:0] span(input logic [CNT_W-1:0] n);
    span = (n == CNT_ZERO) ? CNT_ZERO : n - CNT_ONE;
  endfunction

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_comb begin
    next_state    = state;
    next_is_write = is_write;
    cnt_load      = 1'b0;
    cnt_val       = CNT_ZERO;
    next_rd_valid = 1'b0;
    next_rd_data  = rd_data;
    unique case (state)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          next_is_write = req.write;
          next_state    = ST_SETUP;
          cnt_load      = 1'b1;
          cnt_val       = req.write ? span(timing.write_setup_cycles)
                                    : span(timing.read_setup_cycles);
        end
      end
      ST_SETUP: begin
        if (cnt == CNT_ZERO) begin
          next_state = ST_STROBE;
          cnt_load   = 1'b1;
          cnt_val    = is_write ? span(timing.write_strobe_cycles)
                                : span(timing.read_strobe_cycles);
        end
      end
      ST_STROBE: begin
        if (cnt < READY_LEAD && !ready_sync) begin
          next_state = ST_WAIT;
        end else if (cnt == CNT_ZERO) begin
          next_state = ST_HOLD;
          cnt_load   = 1'b1;
          cnt_val    = is_write ? span(timing.write_hold_cycles)
                                : span(timing.read_hold_cycles);
          if (!is_write) begin
            next_rd_data  = ext_data_in;
            next_rd_valid = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (ready_sync) begin
          next_state = ST_STROBE;
          cnt_load   = 1'b1;
          cnt_val    = CNT_ONE;
        end
      end
      ST_HOLD: begin
        if (cnt == CNT_ZERO) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Pin values, registered from next state
  // ----------------------------------------
  always_comb begin
    in_strobe            = (next_state == ST_STROBE)
                         || (next_state == ST_WAIT);
    next_req_ready       = (next_state == ST_IDLE);
    next_chip_select_n   = 1'b1;
    next_byte_enable_n   = BE_N_RST;
    next_ext_addr        = ext_addr;
    next_ext_data_out    = ext_data_out;
    next_ext_data_oe_n   = 1'b1;
    next_output_enable_n = 1'b1;
    next_read_strobe_n   = 1'b1;
    next_write_strobe_n  = 1'b1;
    if (state == ST_IDLE && req_valid && req_ready) begin
      next_ext_addr     = req.addr;
      next_ext_data_out = req.wdata;
    end
    if (next_state != ST_IDLE) begin
      next_chip_select_n = 1'b0;
      next_byte_enable_n = (state == ST_IDLE) ? ~req.byte_en
                                              : byte_enable_n;
      next_ext_data_oe_n   = ~next_is_write;
      next_output_enable_n = next_is_write;
      next_read_strobe_n   = ~(in_strobe && !next_is_write);
      next_write_strobe_n  = ~(in_strobe && next_is_write);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state           <= ST_IDLE;
      is_write        <= 1'b0;
      req_ready       <= 1'b0;
      rd_valid        <= 1'b0;
      rd_data         <= DATA_RST;
      chip_select_n   <= 1'b1;
      byte_enable_n   <= BE_N_RST;
      ext_addr        <= ADDR_RST;
      ext_data_out    <= DATA_RST;
      ext_data_oe_n   <= 1'b1;
      output_enable_n <= 1'b1;
      read_strobe_n   <= 1'b1;
      write_strobe_n  <= 1'b1;
    end else begin
      state           <= next_state;
      is_write        <= next_is_write;
      req_ready       <= next_req_ready;
      rd_valid        <= next_rd_valid;
      rd_data         <= next_rd_data;
      chip_select_n   <= next_chip_select_n;
      byte_enable_n   <= next_byte_enable_n;
      ext_addr        <= next_ext_addr;
      ext_data_out    <= next_ext_data_out;
      ext_data_oe_n   <= next_ext_data_oe_n;
      output_enable_n <= next_output_enable_n;
      read_strobe_n   <= next_read_strobe_n;
      write_strobe_n  <= next_write_strobe_n;
    end
  end

endmodule

`default_nettype wire

// file: verif/aams_mem_model.sv
/*
  Memory side model: 16 words, ready held low for a stall count.
  Assumes the sequencer pins and a stall count from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module aams_mem_model
  import aams_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [5:0]        stall,
  input  wire logic              chip_select_n,
  input  wire logic              output_enable_n,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [ADDR_W-1:0] ext_addr,
  input  wire logic [DATA_W-1:0] ext_data_out,
  output var  logic [DATA_W-1:0] ext_data_in,
  output var  logic              async_ready_in
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last = '0;
  logic [5:0]        cnt  = 6'h00;
  logic              busy = 1'b0;
  initial for (int i = 0; i < 16; i++) mem[i] = 32'hA5A50000 | i;
  always @(posedge clk) begin
    last <= ext_data_in;
    if (!chip_select_n && !write_strobe_n)
      mem[ext_addr[3:0]] <= ext_data_out;
    if (read_strobe_n && write_strobe_n) begin
      busy <= 1'b0;
      cnt  <= 6'h00;
    end else if (!busy) begin
      busy <= 1'b1;
      cnt  <= stall;
    end else if (cnt != 6'h00)
      cnt <= cnt - 6'h01;
  end
  // Ready drops as soon as a strobe falls, when stall is nonzero
  assign async_ready_in = !((!read_strobe_n || !write_strobe_n) &&
                            (busy ? (cnt != 6'h00) : (stall != 6'h00)));
  // Undriven bus toggles every cycle
  assign ext_data_in = (!chip_select_n && !output_enable_n) ?
                       mem[ext_addr[3:0]] : ~last;
endmodule
`default_nettype wire

// file: verif/aams_sequencer_chk.sv
/*
  Pin checker of the sequencer.
  Assumes binding to aams_sequencer.
*/
`timescale 1ns/10ps
`default_nettype none
module aams_sequencer_chk
  import aams_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire aams_timing_t      timing,
  input wire logic              req_ready,
  input wire logic              rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              async_ready_in,
  input wire logic              chip_select_n,
  input wire logic [DATA_W-1:0] ext_data_in,
  input wire logic              ext_data_oe_n,
  input wire logic              output_enable_n,
  input wire logic              read_strobe_n,
  input wire logic              write_strobe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [6:0] setc, holdc, next_setc, next_holdc;
  function automatic logic [6:0] eff(input logic [5:0] v);
    return (v == 6'h00) ? 7'h01 : {1'b0, v};
  endfunction
  always_comb begin
    next_setc  = chip_select_n ? 7'h00 : setc + 7'h01;
    next_holdc = (chip_select_n || !write_strobe_n) ? 7'h00 :
                 holdc + 7'h01;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      setc  <= 7'h00;
      holdc <= 7'h00;
    end else begin
      setc  <= next_setc;
      holdc <= next_holdc;
    end
  end
  sequence rd_go_s; $fell(read_strobe_n); endsequence
  sequence wr_go_s; $fell(write_strobe_n); endsequence
  sequence stall_s; (!async_ready_in && !read_strobe_n) [*6]; endsequence
  rd_sel_a: assert property (
    !read_strobe_n |-> !chip_select_n && !output_enable_n && ext_data_oe_n)
    else $error("read strobe outside select");
  wr_sel_a: assert property (
    !write_strobe_n |-> !chip_select_n && !ext_data_oe_n && output_enable_n)
    else $error("write strobe outside select");
  rd_setup_a: assert property (
    rd_go_s |-> setc == eff(timing.read_setup_cycles))
    else $error("read setup count");
  wr_setup_a: assert property (
    wr_go_s |-> setc == eff(timing.write_setup_cycles))
    else $error("write setup count");
  wr_hold_a: assert property (
    $rose(chip_select_n) && !$past(ext_data_oe_n) |->
      holdc == eff(timing.write_hold_cycles))
    else $error("write hold count");
  rd_pulse_a: assert property (
    rd_valid == $rose(read_strobe_n)) else $error("read valid timing");
  rd_data_a: assert property (
    rd_valid |-> rd_data == $past(ext_data_in)) else $error("read data");
  stall_hold_a: assert property (
    stall_s |=> !read_strobe_n) else $error("strobe ended while stalled");
  busy_a: assert property (
    !chip_select_n |-> !req_ready) else $error("ready during access");
endmodule
bind aams_sequencer aams_sequencer_chk chk (.clk, .sys_rst, .timing,
  .req_ready, .rd_valid, .rd_data, .async_ready_in, .chip_select_n,
  .ext_data_in, .ext_data_oe_n, .output_enable_n, .read_strobe_n,
  .write_strobe_n);
`default_nettype wire

// file: verif/tb_aams_sequencer.sv
/*
  Bench of the sequencer: accesses with phase counts and data.
  Assumes the memory model and checker files are compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_aams_sequencer
  import aams_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
  aams_req_t req = '0;
  aams_timing_t timing = '0;
  logic [5:0] stall = 6'h00;
  logic req_ready, rd_valid, chip_select_n, ext_data_oe_n, output_enable_n;
  logic read_strobe_n, write_strobe_n, async_ready_in;
  logic [BE_W-1:0] byte_enable_n;
  logic [ADDR_W-1:0] ext_addr;
  logic [DATA_W-1:0] rd_data, ext_data_in, ext_data_out;
  int miscompares = 0, comparisons = 0;
  always #2 clk = ~clk;
  aams_sequencer uut (.clk, .sys_rst, .req_valid, .req, .timing,
    .req_ready, .rd_valid, .rd_data, .async_ready_in, .chip_select_n,
    .byte_enable_n, .ext_addr, .ext_data_in, .ext_data_out,
    .ext_data_oe_n, .output_enable_n, .read_strobe_n, .write_strobe_n);
  aams_mem_model mem (.clk, .stall, .chip_select_n, .output_enable_n,
    .read_strobe_n, .write_strobe_n, .ext_addr, .ext_data_out,
    .ext_data_in, .async_ready_in);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int eff(input logic [5:0] v);
    return (v == 6'h00) ? 1 : int'(v);
  endfunction
  task automatic access(input logic wr, input logic [19:0] a,
                        input logic [31:0] d, input int xlo, input int xhi);
    int ns, nt, nh, k, st;
    logic [31:0] got;
    ns = 0; nt = 0; nh = 0; got = '0;
    req = '{wr, a, a[3:0], d};
    req_valid = 1'b1;
    for (k = 0; k < 50 && req_ready !== 1'b1; k++) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 1'b0;
    chk({output_enable_n, ext_data_oe_n, byte_enable_n, ext_addr},
        {wr, ~wr, ~a[3:0], a});
    for (k = 0; k < 200 && chip_select_n === 1'b0; k++) begin
      if ((wr ? write_strobe_n : read_strobe_n) === 1'b0) nt++;
      else if (nt == 0) ns++;
      else nh++;
      if (rd_valid === 1'b1) got = rd_data;
      @(posedge clk) #1;
    end
    st = eff(wr ? timing.write_strobe_cycles : timing.read_strobe_cycles);
    chk(nt >= st + xlo && nt <= st + xhi, 1);
    chk({ns, nh}, wr ? {eff(timing.write_setup_cycles),
        eff(timing.write_hold_cycles)} : {eff(timing.read_setup_cycles),
        eff(timing.read_hold_cycles)});
    if (!wr) chk(got, d);
  endtask
  task automatic end_sim;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #20000;
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk({req_ready, chip_select_n, read_strobe_n, write_strobe_n}, 4'h7);
    sys_rst = 1'b0;
    timing = {6'h01, 6'h03, 6'h02, 6'h01, 6'h03, 6'h02};
    access(1'b1, 20'h00003, 32'hCAFE1234, 0, 0);
    access(1'b0, 20'h00003, 32'hCAFE1234, 0, 0);
    $display("basic done");
    timing = {6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07};
    access(1'b1, 20'h00015, 32'h0BADF00D, 0, 0);
    access(1'b0, 20'h00015, 32'h0BADF00D, 0, 0);
    access(1'b0, 20'h00016, 32'hA5A50006, 0, 0);
    timing = '0;
    access(1'b1, 20'h0000F, 32'h12345678, 0, 0);
    access(1'b0, 20'h0000F, 32'h12345678, 0, 0);
    $display("settings done");
    timing = {6'h01, 6'h0A, 6'h01, 6'h01, 6'h0A, 6'h01};
    stall = 6'h02;
    access(1'b0, 20'h0000F, 32'h12345678, 0, 0);
    timing = {6'h01, 6'h03, 6'h02, 6'h01, 6'h03, 6'h02};
    stall = 6'h06;
    access(1'b1, 20'h00001, 32'h0F0F0F0F, 7, 10);
    access(1'b0, 20'h00001, 32'h0F0F0F0F, 7, 10);
    $display("ready done");
    end_sim;
  end
endmodule
`default_nettype wire
